// ---- pmc_regs.sv ----
// timing message configuration registers and message classification
// How it works
// - duration low word counts 25MHz cycles of temporary rate adjustment
// - high and low duration words join into one 32-bit duration
// - while running, rate value added or subtracted each 25MHz tick
// - config one bit 6 globally enables timing mode, resets zero
// - bits 5,4,3 enable raw Ethernet, IPv4/UDP, IPv6/UDP detection, reset one
// - bit 2 picks peer-to-peer (one) or end-to-end (zero) transparent clock
// - bit 1 makes host port master (one) or slave (zero)
// - unicast enabled: UDP port 319/320, non-reserved address, lookup forwarding
// - unicast disabled: only multicast timing frames recognised
// - alternate master on: same-domain Sync/Delay_Req go to other non-host ports
// - alternate master off: those frames dropped toward host and all other ports; other domains forwarded
// - bit 10 set: every timing message uses highest-priority queue
// - bit 10 clear: only event messages use highest-priority queue
// - bit 9 set: Follow_up reaches host only when it matches its Sync
`timescale 1ns/1ps
module pmc_regs
    import pmc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        tick_25m,
    input  wire logic        adj_enable,
    input  wire logic        rate_dir,
    input  wire logic [29:0] sub_ns_rate,
    output logic             adj_active,
    output logic             adj_step,
    output logic             adj_add,
    output logic [29:0]      adj_delta,
    output logic             ptp_enable,
    output logic             p2p_mode,
    output logic             host_master,
    input  wire logic        msg_valid,
    input  wire logic        msg_is_l2,
    input  wire logic        msg_is_ipv4,
    input  wire logic        msg_is_ipv6,
    input  wire logic [15:0] msg_udp_port,
    input  wire logic        msg_multicast,
    input  wire logic        msg_reserved_addr,
    input  wire logic [3:0]  msg_type,
    input  wire logic        msg_same_domain,
    input  wire logic        msg_from_host,
    input  wire logic        msg_from_master,
    input  wire logic        msg_fu_match,
    output logic             cls_valid,
    output logic             cls_is_ptp,
    output logic             cls_use_lookup,
    output logic             cls_to_host,
    output logic             cls_to_nonhost,
    output logic             cls_high_queue
);
    logic [15:0] dur_high;
    logic [15:0] dur_low;
    logic [15:0] cfg_one;
    logic [15:0] cfg_two;

    function automatic logic is_event_msg(input logic [3:0] t);
        return (t[3] == 1'b0);
    endfunction

    function automatic logic is_sync_or_dreq(input logic [3:0] t);
        return (t == PMC_MSG_SYNC) || (t == PMC_MSG_DELAY_REQ);
    endfunction

    // register writes; reserved bits keep their fixed values
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dur_high <= PMC_DUR_RESET;
            dur_low  <= PMC_DUR_RESET;
            cfg_one  <= PMC_CFG_ONE_RESET;
            cfg_two  <= PMC_CFG_TWO_RESET;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                PMC_DUR_HIGH_OFS: dur_high <= reg_wdata;
                PMC_DUR_LOW_OFS:  dur_low  <= reg_wdata;
                PMC_CFG_ONE_OFS:
                    cfg_one <= (reg_wdata & PMC_CFG_ONE_WMASK)
                             | (PMC_CFG_ONE_RESET & ~PMC_CFG_ONE_WMASK);
                PMC_CFG_TWO_OFS:  cfg_two  <= reg_wdata & PMC_CFG_TWO_WMASK;
                default: ;
            endcase
        end
    end

    // read data registered; unmapped addresses read zero
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else if (ce) begin
            case (reg_addr)
                PMC_DUR_HIGH_OFS: reg_rdata <= dur_high;
                PMC_DUR_LOW_OFS:  reg_rdata <= dur_low;
                PMC_CFG_ONE_OFS:  reg_rdata <= cfg_one & PMC_CFG_ONE_RMASK;
                PMC_CFG_TWO_OFS:  reg_rdata <= cfg_two;
                default:          reg_rdata <= 16'h0000;
            endcase
        end
    end

    assign ptp_enable  = cfg_one[PMC_PTP_EN_BIT];
    assign p2p_mode    = cfg_one[PMC_P2P_BIT];
    assign host_master = cfg_one[PMC_MASTER_BIT];

    pmc_adj_timer u_adj (
        .clk_sys     (clk_sys),
        .rst_b       (rst_b),
        .ce          (ce),
        .tick_25m    (tick_25m),
        .adj_enable  (adj_enable),
        .rate_dir    (rate_dir),
        .sub_ns_rate (sub_ns_rate),
        .dur_high    (dur_high),
        .dur_low     (dur_low),
        .adj_active  (adj_active),
        .adj_step    (adj_step),
        .adj_add     (adj_add),
        .adj_delta   (adj_delta)
    );

    // message classification
    logic transport_ok;
    logic udp_ptp_port;
    logic unicast_hit;
    logic next_is_ptp;
    logic next_lookup;
    logic next_to_host;
    logic next_to_nonhost;
    logic next_high_queue;

    always_comb begin
        transport_ok = (msg_is_l2   && cfg_one[PMC_L2_EN_BIT])
                    || (msg_is_ipv4 && cfg_one[PMC_V4_EN_BIT])
                    || (msg_is_ipv6 && cfg_one[PMC_V6_EN_BIT]);
        udp_ptp_port = (msg_udp_port == PMC_UDP_EVENT_PORT)
                    || (msg_udp_port == PMC_UDP_GENERAL_PORT);
        unicast_hit  = cfg_two[PMC_UNICAST_BIT] && (msg_is_ipv4 || msg_is_ipv6)
                    && udp_ptp_port && !msg_reserved_addr;
        next_is_ptp  = ptp_enable && transport_ok
                    && (msg_multicast || unicast_hit);
        next_lookup     = next_is_ptp && unicast_hit;
        next_to_host    = next_is_ptp && !msg_from_host;
        next_to_nonhost = next_is_ptp;
        if (next_is_ptp && !unicast_hit && is_sync_or_dreq(msg_type)
            && !msg_from_host && msg_from_master && msg_same_domain) begin
            next_to_nonhost = cfg_two[PMC_ALT_MST_BIT];
            next_to_host    = cfg_two[PMC_ALT_MST_BIT];
        end
        if (next_is_ptp && cfg_two[PMC_FU_CHK_BIT] && msg_type == PMC_MSG_FOLLOW_UP) begin
            next_to_host = next_to_host && msg_fu_match;
        end
        next_high_queue = next_is_ptp
                       && (cfg_two[PMC_ALL_PRIO_BIT] || is_event_msg(msg_type));
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cls_valid      <= 1'b0;
            cls_is_ptp     <= 1'b0;
            cls_use_lookup <= 1'b0;
            cls_to_host    <= 1'b0;
            cls_to_nonhost <= 1'b0;
            cls_high_queue <= 1'b0;
        end else if (ce) begin
            cls_valid      <= msg_valid;
            cls_is_ptp     <= msg_valid && next_is_ptp;
            cls_use_lookup <= msg_valid && next_lookup;
            cls_to_host    <= msg_valid && next_to_host;
            cls_to_nonhost <= msg_valid && next_to_nonhost;
            cls_high_queue <= msg_valid && next_high_queue;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_msg_in;
        ce && msg_valid;
    endsequence

    a_ptp_gated_off: assert property ((s_msg_in and !ptp_enable) |=> !cls_is_ptp)
        else $error("timing frame seen while disabled");
    a_l2_detect_off: assert property (
        (s_msg_in and (msg_is_l2 && !msg_is_ipv4 && !msg_is_ipv6
        && !cfg_one[PMC_L2_EN_BIT])) |=> !cls_is_ptp)
        else $error("raw frame detected while disabled");
    a_unicast_seen: assert property (
        (s_msg_in and (ptp_enable && msg_is_ipv4 && cfg_one[PMC_V4_EN_BIT]
        && cfg_two[PMC_UNICAST_BIT] && !msg_reserved_addr
        && msg_udp_port == PMC_UDP_EVENT_PORT)) |=> cls_is_ptp && cls_use_lookup)
        else $error("unicast timing frame missed");
    a_multicast_only: assert property (
        (s_msg_in and (!cfg_two[PMC_UNICAST_BIT] && !msg_multicast)) |=> !cls_is_ptp)
        else $error("unicast accepted while disabled");
    a_alt_master_fwd: assert property (
        (s_msg_in and (next_is_ptp && !unicast_hit && msg_type == PMC_MSG_SYNC
        && !msg_from_host && msg_from_master && msg_same_domain))
        |=> cls_to_nonhost == $past(cfg_two[PMC_ALT_MST_BIT])
        && cls_to_host == cls_to_nonhost)
        else $error("same-domain sync forwarding wrong");
    a_other_domain: assert property (
        (s_msg_in and (next_is_ptp && msg_type == PMC_MSG_SYNC && !msg_same_domain))
        |=> cls_to_nonhost)
        else $error("other-domain sync not forwarded");
    a_prio_queue: assert property (
        (s_msg_in and next_is_ptp) |=> cls_high_queue
        == ($past(cfg_two[PMC_ALL_PRIO_BIT]) || !$past(msg_type[3])))
        else $error("queue choice wrong");
    a_fu_check: assert property (
        (s_msg_in and (cfg_two[PMC_FU_CHK_BIT] && msg_type == PMC_MSG_FOLLOW_UP
        && !msg_fu_match)) |=> !cls_to_host)
        else $error("unmatched follow_up sent to host");
    a_mode_bits: assert property (
        ce && reg_wr && reg_addr == PMC_CFG_ONE_OFS
        |=> p2p_mode == $past(reg_wdata[PMC_P2P_BIT])
        && host_master == $past(reg_wdata[PMC_MASTER_BIT]))
        else $error("mode bits not written");
endmodule

// ---- pmc_pkg.sv ----
// constants for the timing message configuration registers
package pmc_pkg;
    localparam logic [15:0] PMC_DUR_HIGH_OFS  = 16'h0510;
    localparam logic [15:0] PMC_DUR_LOW_OFS   = 16'h0512;
    localparam logic [15:0] PMC_CFG_ONE_OFS   = 16'h0514;
    localparam logic [15:0] PMC_CFG_TWO_OFS   = 16'h0516;

    localparam logic [15:0] PMC_DUR_RESET     = 16'h0000;
    localparam logic [15:0] PMC_CFG_ONE_RESET = 16'h0039;
    localparam logic [15:0] PMC_CFG_ONE_WMASK = 16'h007E;
    localparam logic [15:0] PMC_CFG_ONE_RMASK = 16'h007F;
    localparam logic [15:0] PMC_CFG_TWO_RESET = 16'h1000;
    localparam logic [15:0] PMC_CFG_TWO_WMASK = 16'h1E00;

    localparam int PMC_PTP_EN_BIT  = 6;
    localparam int PMC_L2_EN_BIT   = 5;
    localparam int PMC_V4_EN_BIT   = 4;
    localparam int PMC_V6_EN_BIT   = 3;
    localparam int PMC_P2P_BIT     = 2;
    localparam int PMC_MASTER_BIT  = 1;
    localparam int PMC_UNICAST_BIT = 12;
    localparam int PMC_ALT_MST_BIT = 11;
    localparam int PMC_ALL_PRIO_BIT = 10;
    localparam int PMC_FU_CHK_BIT  = 9;

    localparam logic [15:0] PMC_UDP_EVENT_PORT   = 16'h013F;
    localparam logic [15:0] PMC_UDP_GENERAL_PORT = 16'h0140;

    localparam logic [3:0] PMC_MSG_SYNC      = 4'h0;
    localparam logic [3:0] PMC_MSG_DELAY_REQ = 4'h1;
    localparam logic [3:0] PMC_MSG_FOLLOW_UP = 4'h8;

    localparam int PMC_ADJ_TICK_MHZ = 25;

    typedef enum logic [1:0] {PMC_ADJ_IDLE, PMC_ADJ_RUN, PMC_ADJ_DONE} pmc_adj_state_t;
endpackage

// ---- pmc_adj_timer.sv ----
// temporary clock-rate adjustment duration timer
`timescale 1ns/1ps
module pmc_adj_timer
    import pmc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        tick_25m,
    input  wire logic        adj_enable,
    input  wire logic        rate_dir,
    input  wire logic [29:0] sub_ns_rate,
    input  wire logic [15:0] dur_high,
    input  wire logic [15:0] dur_low,
    output logic             adj_active,
    output logic             adj_step,
    output logic             adj_add,
    output logic [29:0]      adj_delta
);
    pmc_adj_state_t state;
    logic [31:0]    remaining;

    assign adj_active = (state == PMC_ADJ_RUN);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state     <= PMC_ADJ_IDLE;
            remaining <= 32'h00000000;
        end else if (ce) begin
            case (state)
                PMC_ADJ_IDLE: begin
                    if (adj_enable) begin
                        remaining <= {dur_high, dur_low};
                        state     <= ({dur_high, dur_low} == 32'h00000000) ?
                                     PMC_ADJ_DONE : PMC_ADJ_RUN;
                    end
                end
                PMC_ADJ_RUN: begin
                    if (!adj_enable) begin
                        state <= PMC_ADJ_IDLE;
                    end else if (tick_25m) begin
                        remaining <= remaining - 32'h00000001;
                        if (remaining == 32'h00000001) begin
                            state <= PMC_ADJ_DONE;
                        end
                    end
                end
                PMC_ADJ_DONE: begin
                    if (!adj_enable) begin
                        state <= PMC_ADJ_IDLE;
                    end
                end
                default: state <= PMC_ADJ_IDLE;
            endcase
        end
    end

    // one step of the rate value per 25MHz tick while running
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            adj_step  <= 1'b0;
            adj_add   <= 1'b0;
            adj_delta <= 30'h00000000;
        end else if (ce) begin
            adj_step  <= adj_active && adj_enable && tick_25m;
            adj_add   <= rate_dir;
            adj_delta <= sub_ns_rate;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_last_tick;
        ce && adj_active && adj_enable && tick_25m && remaining == 32'h00000001;
    endsequence

    a_step_needs_run: assert property (
        ce && !(adj_active && adj_enable && tick_25m) |=> !adj_step)
        else $error("step without running adjustment");
    a_count_down_one: assert property (
        ce && adj_active && adj_enable && tick_25m
        |=> remaining == $past(remaining) - 32'h00000001)
        else $error("duration not decremented by one");
    a_stop_at_zero: assert property (s_last_tick |=> !adj_active ##1 !adj_step)
        else $error("adjustment outlived its duration");
    a_load_duration: assert property (
        ce && state == PMC_ADJ_IDLE && adj_enable
        && {dur_high, dur_low} != 32'h00000000 |=> adj_active
        && remaining == {$past(dur_high), $past(dur_low)})
        else $error("duration not loaded from both words");
endmodule

// ---- pmc_regs_bench.sv ----
// self-checking bench for the timing message configuration registers
`timescale 1ns/1ps
module pmc_regs_bench
    import pmc_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        ce = 1'b1;
    logic        reg_wr = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic        tick_25m = 1'b0, adj_enable = 1'b0, rate_dir = 1'b0;
    logic [29:0] sub_ns_rate = 30'h00000000;
    logic [29:0] adj_delta;
    logic        adj_active, adj_step, adj_add, ptp_enable, p2p_mode, host_master;
    logic        msg_valid = 1'b0, msg_is_l2 = 1'b0, msg_is_ipv4 = 1'b0, msg_is_ipv6 = 1'b0;
    logic        msg_multicast = 1'b0, msg_reserved_addr = 1'b0, msg_same_domain = 1'b0;
    logic        msg_from_host = 1'b0, msg_from_master = 1'b0, msg_fu_match = 1'b0;
    logic [15:0] msg_udp_port = 16'h0000;
    logic [3:0]  msg_type = 4'h0;
    logic        cls_valid, cls_is_ptp, cls_use_lookup, cls_to_host, cls_to_nonhost;
    logic        cls_high_queue;
    int          errors = 0;
    int          check_count = 0;
    int          steps, n;
    logic [15:0] lfsr = 16'hF19B;
    logic [15:0] mdl[4] = '{16'h0000, 16'h0000, 16'h0039, 16'h1000};
    logic [15:0] wm[4] = '{16'hFFFF, 16'hFFFF, 16'h007E, 16'h1E00};
    logic [15:0] ptbl[4] = '{16'h013F, 16'h0140, 16'h013E, 16'h0141};
    logic [15:0] th[4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001};
    logic [15:0] tl[4] = '{16'h0000, 16'h0001, 16'h0007, 16'h0000};
    logic [15:0] a, b, d, s, t;
    logic [3:0]  typ;
    logic        v;
    logic [5:0]  prev, nx;

    pmc_regs dut_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tick_25m(tick_25m),
        .adj_enable(adj_enable), .rate_dir(rate_dir), .sub_ns_rate(sub_ns_rate),
        .adj_active(adj_active), .adj_step(adj_step), .adj_add(adj_add),
        .adj_delta(adj_delta), .ptp_enable(ptp_enable), .p2p_mode(p2p_mode),
        .host_master(host_master), .msg_valid(msg_valid), .msg_is_l2(msg_is_l2),
        .msg_is_ipv4(msg_is_ipv4), .msg_is_ipv6(msg_is_ipv6), .msg_udp_port(msg_udp_port),
        .msg_multicast(msg_multicast), .msg_reserved_addr(msg_reserved_addr),
        .msg_type(msg_type), .msg_same_domain(msg_same_domain),
        .msg_from_host(msg_from_host), .msg_from_master(msg_from_master),
        .msg_fu_match(msg_fu_match), .cls_valid(cls_valid), .cls_is_ptp(cls_is_ptp),
        .cls_use_lookup(cls_use_lookup), .cls_to_host(cls_to_host),
        .cls_to_nonhost(cls_to_nonhost), .cls_high_queue(cls_high_queue)
    );

    always #50 clk_sys = ~clk_sys;

    function automatic logic [15:0] rnd();
        lfsr = {1'b0, lfsr[15:1]} ^ (lfsr[0] ? 16'hB400 : 16'h0000);
        return lfsr;
    endfunction

    function automatic logic [15:0] exp_rd(input logic [15:0] ad);
        return (ad[15:3] == 13'h00A2 && !ad[0]) ? mdl[ad[2:1]] : 16'h0000;
    endfunction

    // sv: 0 valid, 2:1 transport, 3 multicast, 5 same domain, 6 from host, 7 master, 8 match
    function automatic logic [5:0] cls_exp(input logic vl, input logic [15:0] sv,
                                           input logic [15:0] pt, input logic [3:0] ty);
        logic uni, ptp, alt, host, tr;
        uni  = mdl[3][12] && sv[2:1] != 2'b00 && (pt == 16'h013F || pt == 16'h0140) && !sv[3];
        tr   = (sv[2:1] == 2'b00) ? mdl[2][5] : (sv[2:1] == 2'b10) ? mdl[2][3] : mdl[2][4];
        ptp  = vl && mdl[2][6] && tr && (sv[3] || uni);
        alt  = ptp && !uni && sv[5] && sv[7] && !sv[6] && ty < 4'h2;
        host = alt ? mdl[3][11] : ptp && !sv[6] && !(mdl[3][9] && ty == 4'h8 && !sv[8]);
        return {vl, ptp, ptp && uni, host, alt ? mdl[3][11] : ptp, ptp && (mdl[3][10] || !ty[3])};
    endfunction

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] ad, input logic [15:0] dv);
        @(posedge clk_sys);
        reg_addr  <= ad;
        reg_wdata <= dv;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        if (ad[15:3] == 13'h00A2 && !ad[0])
            mdl[ad[2:1]] = (dv & wm[ad[2:1]]) | ((ad[2:1] == 2'b10) ? 16'h0001 : 16'h0000);
    endtask

    task automatic rd(input logic [15:0] ad);
        @(posedge clk_sys);
        reg_addr <= ad;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic end_of_test();
        if (errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        // reserved bits first with all ones and all zeros, then random traffic
        for (int i = 0; i < 32; i++) begin
            t = rnd();
            a = (i < 4) ? 16'h0514 + {14'h0000, i[0], 1'b0} : 16'h0510 + {12'h000, t[2:0], 1'b0};
            d = (i < 4) ? {16{~i[1]}} : rnd();
            for (int k = 0; k < 5; k++) begin
                b = (k == 4) ? a : 16'h0510 + {13'h0000, k[1:0], 1'b0};
                rd(b);
                chk("rdata", exp_rd(b), reg_rdata);
            end
            chk("mode", {29'h0, mdl[2][6], mdl[2][2], mdl[2][1]},
                {29'h0, ptp_enable, p2p_mode, host_master});
            wr(a, d);
        end
        // a write while the clock enable is low must be lost
        d  = mdl[1];
        ce <= 1'b0;
        wr(16'h0512, ~d);
        mdl[1] = d;
        ce <= 1'b1;
        rd(16'h0512);
        chk("frozen", exp_rd(16'h0512), reg_rdata);
        for (int i = 0; i < 4; i++) begin
            wr(16'h0510, th[i]);
            wr(16'h0512, tl[i]);
            t = rnd();
            rate_dir    <= t[15];
            sub_ns_rate <= {t[13:0], rnd()};
            adj_enable  <= 1'b1;
            steps = 0;
            n = 0;
            do begin
                @(posedge clk_sys);
                t = rnd();
                tick_25m <= |t[1:0];
                #1;
                n++;
                if (adj_step === 1'b1) begin
                    steps++;
                    chk("delta", {1'b0, rate_dir, sub_ns_rate}, {1'b0, adj_add, adj_delta});
                end
            end while (n < 40 && (n < 3 || adj_active === 1'b1));
            chk("active", {31'h0, th[i] != 16'h0000}, {31'h0, adj_active});
            if (th[i] == 16'h0000) chk("steps", {16'h0000, tl[i]}, steps);
            @(posedge clk_sys);
            adj_enable <= 1'b0;
            tick_25m   <= 1'b0;
            repeat (3) @(posedge clk_sys);
            #1 chk("stopped", 32'h0, {31'h0, adj_active});
        end
        prev = 6'h00;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_sys);
            s   = rnd();
            t   = rnd();
            v   = s[0] && (i % 50 != 49);
            typ = (s[12:11] == 2'b11) ? t[15:12] : {s[12], 2'b00, s[11]};
            {msg_valid, msg_is_l2, msg_is_ipv4, msg_is_ipv6, msg_multicast, msg_reserved_addr,
             msg_same_domain, msg_from_host, msg_from_master, msg_fu_match} <=
                {v, s[2:1] == 2'b00, s[1], s[2:1] == 2'b10, s[3], s[3], s[5], s[6], s[7], s[8]};
            msg_udp_port <= s[3] ? ptbl[t[0]] : ptbl[t[1:0]];
            msg_type     <= typ;
            nx = cls_exp(v, s, s[3] ? ptbl[t[0]] : ptbl[t[1:0]], typ);
            #1 chk("class", {26'h0, prev}, {26'h0, cls_valid, cls_is_ptp, cls_use_lookup,
                cls_to_host, cls_to_nonhost, cls_high_queue});
            prev = nx;
            if (i % 50 == 49) begin
                wr(16'h0514, rnd());
                wr(16'h0516, rnd());
            end
        end
        end_of_test();
    end
endmodule
